// ---- general_timer_unit.v ----
// Down-counting general timer with APB register access
`timescale 1ns/100ps
`default_nettype none
`include "general_timer_unit_defines.vh"

module general_timer_unit (
  input wire sys_clk,
  input wire rst_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  output wire irq
);

  reg [31:0] prescale_count_now_r;
  reg [31:0] prescale_count_nxt;
  reg [31:0] prescale_reload_value_r;
  reg [31:0] prescale_reload_nxt;
  reg [31:0] main_count_now_r;
  reg [31:0] main_count_nxt;
  reg [31:0] main_reload_value_r;
  reg [31:0] main_reload_nxt;
  reg run_r;
  reg run_nxt;
  reg repeat_select_r;
  reg repeat_select_nxt;
  reg irq_allow_r;
  reg irq_allow_nxt;
  reg irq_pending_flag_r;
  reg irq_pending_flag_nxt;
  reg single_done_r;
  reg single_done_nxt;
  reg [31:0] prdata_nxt;

  wire wr_en;
  wire rd_setup;
  wire [39:0] ofs_table;
  wire [4:0] sel_vec;
  wire sel_prescale_now;
  wire sel_prescale_reload;
  wire sel_main_count;
  wire sel_main_reload;
  wire sel_control;
  wire wr_prescale_now;
  wire wr_prescale_reload;
  wire wr_main_count;
  wire wr_main_reload;
  wire wr_control;
  wire [31:0] prescale_eff;
  wire prescale_tick;
  wire main_counting;
  wire main_underflow;
  wire force_reload;
  wire pending_clear;
  wire main_restart;
  wire [31:0] control_view;

  // Match of a bus address against one register offset
  function addr_match;
    input [7:0] addr;
    input [7:0] ofs;
    begin
      addr_match = (addr == ofs);
    end
  endfunction

  // One step down of a counter word
  function [31:0] step_down;
    input [31:0] value;
    begin
      step_down = value - 32'h0000_0001;
    end
  endfunction

  // Prescaler period with its lower bound applied
  function [31:0] clamp_period;
    input [31:0] period;
    begin
      if (period < `PRESCALE_MIN) begin
        clamp_period = `PRESCALE_MIN;
      end else begin
        clamp_period = period;
      end
    end
  endfunction

  // Registers always answer in one access cycle
  assign pready = 1'b1;
  assign pslverr = 1'b0;

  // Bus phase decodes
  assign wr_en = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;

  // Offsets of the five registers, highest slot first
  assign ofs_table = {`OFS_CONTROL, `OFS_MAIN_RELOAD, `OFS_MAIN_COUNT,
    `OFS_PRESCALE_RELOAD, `OFS_PRESCALE_NOW};

  // One select per register from the byte address
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi = gi + 1) begin : g_sel
      assign sel_vec[gi] = addr_match(paddr, ofs_table[gi*8 +: 8]);
    end
  endgenerate

  // Named selects
  assign sel_prescale_now = sel_vec[0];
  assign sel_prescale_reload = sel_vec[1];
  assign sel_main_count = sel_vec[2];
  assign sel_main_reload = sel_vec[3];
  assign sel_control = sel_vec[4];

  // Write strobes, one per register
  assign wr_prescale_now = wr_en & sel_prescale_now;
  assign wr_prescale_reload = wr_en & sel_prescale_reload;
  assign wr_main_count = wr_en & sel_main_count;
  assign wr_main_reload = wr_en & sel_main_reload;
  assign wr_control = wr_en & sel_control;

  // Prescaler period clamped to two
  assign prescale_eff = clamp_period(prescale_reload_value_r);

  // Tick when the running prescaler sits at zero
  assign prescale_tick = run_r & (prescale_count_now_r == `RST_WORD);
  assign main_counting = prescale_tick & ~single_done_r;
  assign main_underflow = main_counting & (main_count_now_r == `RST_WORD);

  // Side effects of a control write
  assign force_reload = wr_control & pwdata[`CTL_FORCE_RELOAD];
  assign pending_clear = wr_control & pwdata[`CTL_IRQ_PENDING];
  assign main_restart = force_reload | wr_main_count;

  // Interrupt request gated by the allow bit
  assign irq = irq_allow_r & irq_pending_flag_r;

  // Control word as software reads it; force reload reads zero
  assign control_view = {27'h000_0000, irq_pending_flag_r, irq_allow_r,
    1'b0, repeat_select_r, run_r};

  // Prescaler next value: write, reload after zero, or one step down
  always @* begin
    prescale_count_nxt = prescale_count_now_r;
    if (wr_prescale_now) begin
      prescale_count_nxt = pwdata;
    end else if (prescale_tick) begin
      prescale_count_nxt = step_down(prescale_eff);
    end else if (run_r) begin
      prescale_count_nxt = step_down(prescale_count_now_r);
    end
  end

  // Prescaler period next value
  always @* begin
    prescale_reload_nxt = prescale_reload_value_r;
    if (wr_prescale_reload) begin
      prescale_reload_nxt = pwdata;
    end
  end

  // Main counter next value: force reload, write, reload on underflow, step
  always @* begin
    main_count_nxt = main_count_now_r;
    if (force_reload) begin
      main_count_nxt = main_reload_value_r;
    end else if (wr_main_count) begin
      main_count_nxt = pwdata;
    end else if (main_underflow) begin
      main_count_nxt = main_reload_value_r;
    end else if (main_counting) begin
      main_count_nxt = step_down(main_count_now_r);
    end
  end

  // Main period next value
  always @* begin
    main_reload_nxt = main_reload_value_r;
    if (wr_main_reload) begin
      main_reload_nxt = pwdata;
    end
  end

  // Stored control fields next value
  always @* begin
    run_nxt = run_r;
    repeat_select_nxt = repeat_select_r;
    irq_allow_nxt = irq_allow_r;
    if (wr_control) begin
      run_nxt = pwdata[`CTL_RUN];
      repeat_select_nxt = pwdata[`CTL_REPEAT];
      irq_allow_nxt = pwdata[`CTL_IRQ_ALLOW];
    end
  end

  // Pending flag next value; a set wins over a clear in the same cycle
  always @* begin
    irq_pending_flag_nxt = irq_pending_flag_r;
    if (main_underflow) begin
      irq_pending_flag_nxt = 1'b1;
    end else if (pending_clear) begin
      irq_pending_flag_nxt = 1'b0;
    end
  end

  // Single-shot halt until software reloads or rewrites the counter
  always @* begin
    single_done_nxt = single_done_r;
    if (main_restart) begin
      single_done_nxt = 1'b0;
    end else if (main_underflow && !repeat_select_r) begin
      single_done_nxt = 1'b1;
    end
  end

  // Read multiplexer
  always @* begin
    case (paddr)
      `OFS_PRESCALE_NOW: prdata_nxt = prescale_count_now_r;
      `OFS_PRESCALE_RELOAD: prdata_nxt = prescale_reload_value_r;
      `OFS_MAIN_COUNT: prdata_nxt = main_count_now_r;
      `OFS_MAIN_RELOAD: prdata_nxt = main_reload_value_r;
      `OFS_CONTROL: prdata_nxt = control_view;
      default: prdata_nxt = `RST_WORD;
    endcase
  end

  // Prescaler current value
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prescale_count_now_r <= `RST_WORD;
    end else begin
      prescale_count_now_r <= prescale_count_nxt;
    end
  end

  // Prescaler period
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prescale_reload_value_r <= `RST_WORD;
    end else begin
      prescale_reload_value_r <= prescale_reload_nxt;
    end
  end

  // Main counter current value
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      main_count_now_r <= `RST_WORD;
    end else begin
      main_count_now_r <= main_count_nxt;
    end
  end

  // Main period
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      main_reload_value_r <= `RST_WORD;
    end else begin
      main_reload_value_r <= main_reload_nxt;
    end
  end

  // Stored control fields
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      run_r <= 1'b0;
      repeat_select_r <= 1'b0;
      irq_allow_r <= 1'b0;
    end else begin
      run_r <= run_nxt;
      repeat_select_r <= repeat_select_nxt;
      irq_allow_r <= irq_allow_nxt;
    end
  end

  // Pending flag
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_pending_flag_r <= 1'b0;
    end else begin
      irq_pending_flag_r <= irq_pending_flag_nxt;
    end
  end

  // Single-shot halt state
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      single_done_r <= 1'b0;
    end else begin
      single_done_r <= single_done_nxt;
    end
  end

  // Read data captured in the setup cycle, held through the access phase
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= `RST_WORD;
    end else if (rd_setup) begin
      prdata <= prdata_nxt;
    end
  end

endmodule // general_timer_unit
`default_nettype wire

// ---- general_timer_unit_defines.vh ----
// Constants of the down-counting general timer
// Function
// - The main counter is a 32-bit down-counter that drops by one per prescaler tick.
// - Nothing counts until the run bit is one; with it zero neither counter decrements.
// - The system clock feeds the prescaler and only prescaler ticks decrement the main counter.
// - Both counters count down and reload from their own period register on reaching zero; neither goes to -1.
// - When the main counter is at zero on a prescaler tick the pending flag is set and the main period is reloaded.
// - With repeat select one, counting goes on after each reload and every underflow repeats this.
// - With repeat select zero, the main counter stops decrementing after its first underflow.
// - Writing one to the force-reload bit loads the main period into the main counter at any time.
// - The effective prescaler period is never below 2, whatever software writes.
// - Control bit 4 is the pending flag, read as one when pending, cleared by writing one.
// - Control bit 3 enables the interrupt request, raised while it and the pending flag are set.
// - Prescaler current value sits at 00h and its period at 04h, both read and write.
// - Main current value sits at 10h, main period at 14h, control at 18h, all read and write.
// - Control bit 2 is force-reload, loading the main period into the main counter.
// - Control bit 1 is repeat select: one continuous, zero single-shot.
// - Control bit 0 is the run bit: one lets the timer operate.
`ifndef GENERAL_TIMER_UNIT_DEFINES_VH
`define GENERAL_TIMER_UNIT_DEFINES_VH

`define OFS_PRESCALE_NOW 8'h00
`define OFS_PRESCALE_RELOAD 8'h04
`define OFS_MAIN_COUNT 8'h10
`define OFS_MAIN_RELOAD 8'h14
`define OFS_CONTROL 8'h18

`define CTL_RUN 0
`define CTL_REPEAT 1
`define CTL_FORCE_RELOAD 2
`define CTL_IRQ_ALLOW 3
`define CTL_IRQ_PENDING 4

`define RST_WORD 32'h0000_0000
`define COUNT_UNDERFLOW 32'hFFFF_FFFF
`define PRESCALE_MIN 32'h0000_0002

`endif

// ---- general_timer_unit_tb.sv ----
// Self-checking bench for the down-counting general timer
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fail_count++; \
  $display("mismatch at %0t: got %h want %h", $time, a, b); end end
module general_timer_unit_tb;
  logic sys_clk, rst_n, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r, e;
  logic [31:0] q[$];
  int fail_count = 0;
  int total_checks = 0;
  general_timer_unit dut (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq));
  always #10 sys_clk = ~sys_clk;
  // Compare each finished read with the oldest note
  always @(posedge sys_clk) if ((psel && penable && !pwrite && pready) === 1'b1) begin
    e = q.pop_front();
    `CHK(prdata, e)
  end
  // One APB transfer, held until ready is sampled
  task automatic xf(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge sys_clk) {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge sys_clk) penable <= 1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    {psel, penable} <= 2'b00;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    q.push_back(x);
    xf(a, 0, 0);
  endtask
  // Wait a bounded time for the request line
  task automatic wirq;
    int n;
    n = 0;
    // Let the clearing write settle so a stale request is not taken
    @(posedge sys_clk);
    while (irq !== 1'b1 && n < 60) begin @(posedge sys_clk); n++; end
    `CHK(irq, 1'b1)
  endtask
  task tally_and_finish;
    $display("checks %0d errors %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    #100000;
    fail_count++;
    tally_and_finish;
  end
  // Main sequence
  initial begin
    {sys_clk, rst_n, psel, penable, pwrite, paddr, pwdata} = 0;
    void'($urandom(49592));
    repeat (8) @(posedge sys_clk);
    rst_n <= 1;
    rd(8'h14, 0);
    rd(8'h18, 0);
    r = $urandom;
    xf(8'h0C, 1, r); rd(8'h0C, 0);
    xf(8'h14, 1, r); rd(8'h14, r);
    xf(8'h10, 1, r & 15); rd(8'h10, r & 15);
    xf(8'h04, 1, 1); xf(8'h14, 1, 3); xf(8'h18, 1, 32'h0000_0009);
    wirq;
    rd(8'h18, 32'h0000_0019);
    repeat (20) @(posedge sys_clk);
    rd(8'h10, 3);
    xf(8'h18, 1, 32'h0000_0019); rd(8'h18, 32'h0000_0009);
    `CHK(irq, 1'b0)
    xf(8'h18, 1, 32'h0000_000D); wirq;
    xf(8'h18, 1, 32'h0000_001F); wirq;
    xf(8'h18, 1, 32'h0000_001B); wirq;
    xf(8'h18, 1, 32'h0000_0013); repeat (40) @(posedge sys_clk);
    `CHK(irq, 1'b0)
    rd(8'h18, 32'h0000_0013);
    xf(8'h18, 1, 0); xf(8'h00, 1, 1); repeat (9) @(posedge sys_clk);
    rd(8'h00, 1);
    tally_and_finish;
  end
endmodule // general_timer_unit_tb
`default_nettype wire

// ---- timer_port_chk_asserts.sv ----
// Port checker for the down-counting general timer
`timescale 1ns/100ps
`default_nettype none
module timer_port_chk (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Bus phase decodes
  wire rs = psel && !penable && !pwrite;
  wire ra = psel && penable && !pwrite;
  wire wa = psel && penable && pwrite;
  rdy_high_a: assert property (pready) else $error("ready low");
  no_error_a: assert property (!pslverr) else $error("error raised");
  irq_mask_a: assert property (wa && paddr == 8'h18 && !pwdata[3] |=> !irq)
    else $error("irq while disabled");
  ctl_read_a: assert property (ra && paddr == 8'h18 |-> prdata[31:5] == 0 && !prdata[2])
    else $error("control read bad");
  unmap_read_a: assert property (ra && !(paddr inside {0, 4, 16, 20, 24}) |-> prdata == 0)
    else $error("unmapped read nonzero");
  reload_back_a: assert property (wa && paddr == 8'h14 ##2 rs && paddr == 8'h14
    |=> prdata == $past(pwdata, 3)) else $error("period readback bad");
  read_hold_a: assert property (!rs |=> $stable(prdata)) else $error("read data moved");
  irq_match_a: assert property (rs && paddr == 8'h18 |=> (prdata[4] & prdata[3]) == $past(irq))
    else $error("irq and flags differ");
  cover property ($rose(irq));
  cover property (ra && paddr == 8'h10);
  cover property (wa && paddr == 8'h18 && pwdata[2]);
endmodule // timer_port_chk
bind general_timer_unit timer_port_chk chk (.sys_clk, .rst_n, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .irq);
`default_nettype wire
